/* File: rtl/cipv_map.svh */
// Constants, offsets and status codes of the card command block
`ifndef CIPV_MAP_SVH
`define CIPV_MAP_SVH
// **********
// Instruction codes
// **********
`define CIPV_INS_INC 8'h32
`define CIPV_INS_VFY 8'h20
`define CIPV_AM_TAG 8'h84
`define CIPV_SFI_MODE 3'h4
// **********
// Lengths and counts
// **********
`define CIPV_PIN_LEN 8'h08
`define CIPV_LC_MAX 8'h7f
`define CIPV_RETRY_INIT 2'h3
`define CIPV_PIN0_REF 8'h01
`define CIPV_PIN1_REF 8'h81
`define CIPV_RECLEN_RST 7'h08
// **********
// Status words
// **********
`define CIPV_SW_OK 16'h9000
`define CIPV_SW_RETRY 16'h63c0
`define CIPV_SW_BLOCKED 16'h6983
`define CIPV_SW_DISABLED 16'h6984
`define CIPV_SW_NO_AC 16'h6982
`define CIPV_SW_BAD_P 16'h6b00
`define CIPV_SW_BAD_LEN 16'h6700
`define CIPV_SW_NO_FILE 16'h6a82
`define CIPV_SW_NO_REF 16'h6a88
`define CIPV_SW_MAX 16'h9850
`define CIPV_SW_BAD_INS 16'h6d00
// **********
// Register offsets
// **********
`define CIPV_R_ACRULE 8'h00
`define CIPV_R_PINCTL 8'h04
`define CIPV_R_PINSTAT 8'h08
`define CIPV_R_RECLEN 8'h0c
`define CIPV_R_RECACC 8'h10
`define CIPV_R_RECDATA 8'h14
`define CIPV_R_PIN0_LO 8'h18
`define CIPV_R_PIN0_HI 8'h1c
`define CIPV_R_PIN1_LO 8'h20
`define CIPV_R_PIN1_HI 8'h24
`define CIPV_R_IRQ_STAT 8'h28
`define CIPV_R_IRQ_MASK 8'h2c
// **********
// Interrupt bits
// **********
`define CIPV_IRQ_DONE 0
`define CIPV_IRQ_BLOCK 1
`define CIPV_IRQ_INC 2
`define CIPV_IRQ_BADPIN 3
`endif

/* File: rtl/cipv_pkg.sv */
// Types shared by the card command block
package cipv_pkg;
   // Command header as delivered by the transport
   typedef struct packed {
      logic [7:0] cla;
      logic [7:0] ins;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] lc;
      logic le_present;
   } cipv_cmd_t;
   // Register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } cipv_reg_req_t;
   // Command sequencer states, one-hot
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_RX = 6'h02,
      S_EXEC = 6'h04,
      S_ADD = 6'h08,
      S_TX = 6'h10,
      S_DONE = 6'h20
   } cipv_state_t;
endpackage : cipv_pkg

/* File: rtl/cipv_core.sv */
// Increase and PIN verify command engine of the card
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "cipv_map.svh"
module cipv_core import cipv_pkg::*; (
   input logic clk,
   input logic rst_n,
   input logic session_start,
   input logic cmd_valid,
   input cipv_cmd_t cmd,
   output logic cmd_ready,
   input logic din_valid,
   input logic [7:0] din_byte,
   output logic din_ready,
   output logic dout_valid,
   output logic [7:0] dout_byte,
   output logic resp_valid,
   output logic [15:0] resp_sw,
   input cipv_reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   output logic irq
);
   // **********
   // Storage, state and decoding
   // **********
   cipv_state_t st_q; // Sequencer state
   cipv_cmd_t hdr_q; // Latched header
   logic [7:0] cnt_q; // Byte index for receive and send
   logic [6:0] idx_q; // Adder byte index
   logic carry_q; // Adder carry
   logic [15:0] sw_q; // Pending status word
   logic [7:0] din_buf [128]; // Command data
   logic [7:0] sum_buf [128]; // New record, held until committed
   logic [7:0] rec_mem [4][128]; // Cyclic file records
   logic [1:0] cur_q, old_slot; // Slots of record 1 and of the oldest record
   logic [7:0] ac_tag_q, ac_ins_q; // Access rule of the file
   logic [1:0] ac_cond_q; // 0 always, 1 pin0, 2 pin1, 3 never
   logic [4:0] sfi_q; // Short id of the cyclic file
   logic [1:0] pin_dis_q; // PIN disabled flags
   logic [6:0] reclen_q, racc_byte_q; // Record length, software byte pointer
   logic [1:0] racc_slot_q; // Software record slot pointer
   logic [63:0] pin_ref_q [2]; // Reference PINs
   logic [1:0] retry_q [2]; // Remaining attempts
   logic [1:0] blocked_q, verified_q; // Blocked flags; status shared by all channels
   logic [3:0] irq_stat_q, irq_mask_q; // Interrupt status and mask
   logic dout_valid_q; // Send strobe
   logic [7:0] dout_byte_q; // Send byte
   logic [31:0] rdata_q; // Read data
   logic [1:0] pin_ok_p, pin_bad_p, unblk_p; // Per-PIN events
   logic [3:0] irq_ev; // Interrupt events
   logic wr_hit; // Write strobe alias
   // Maps a qualifier to {known, slot}
   function automatic logic [1:0] ref_slot(input logic [7:0] q);
      ref_slot = 2'h0;
      if (q == `CIPV_PIN0_REF) begin
         ref_slot = 2'h2;
      end else if (q == `CIPV_PIN1_REF) begin
         ref_slot = 2'h3;
      end
   endfunction : ref_slot
   // Builds the retry status word
   function automatic logic [15:0] retry_sw(input logic [1:0] n);
      retry_sw = `CIPV_SW_RETRY | {14'h0, n};
   endfunction : retry_sw
   assign old_slot = cur_q + 2'h1;
   assign wr_hit = reg_req.wr;
   // **********
   // Command evaluation
   // **********
   logic [6:0] add_off; // Where the value starts in the record
   logic [7:0] add_byte; // Value byte aligned to the record end
   logic [8:0] add_sum; // Byte sum with carry
   logic [1:0] rs; // Verify target
   logic ps; // Target slot
   logic [63:0] pin_in; // Presented PIN
   logic cond_ok, ac_ok; // Access condition results
   logic ex_add, ex_ok, ex_bad; // Outcomes
   logic [15:0] ex_sw; // Status of the outcome
   // Presented PIN, first byte on top
   always_comb begin
      pin_in = 64'h0;
      for (int k = 0; k < 8; k++) begin
         pin_in[63 - 8 * k -: 8] = din_buf[k];
      end
   end
   // Increase access condition
   always_comb begin
      case (ac_cond_q)
         2'h0: cond_ok = 1'b1;
         2'h1: cond_ok = verified_q[0] | pin_dis_q[0];
         2'h2: cond_ok = verified_q[1] | pin_dis_q[1];
         default: cond_ok = 1'b0;
      endcase
      ac_ok = (ac_tag_q == `CIPV_AM_TAG) && (ac_ins_q == `CIPV_INS_INC) && cond_ok;
   end
   // Decides what an accepted command does
   always_comb begin
      rs = ref_slot(hdr_q.p2);
      ps = rs[0];
      ex_add = 1'b0;
      ex_ok = 1'b0;
      ex_bad = 1'b0;
      ex_sw = `CIPV_SW_BAD_INS;
      if (hdr_q.ins == `CIPV_INS_INC) begin
         if (hdr_q.p2 != 8'h00 || !(hdr_q.p1 == 8'h00
               || hdr_q.p1[7:5] == `CIPV_SFI_MODE)) begin
            ex_sw = `CIPV_SW_BAD_P;
         end else if (hdr_q.p1 != 8'h00 && hdr_q.p1[4:0] != sfi_q) begin
            ex_sw = `CIPV_SW_NO_FILE;
         end else if (hdr_q.lc == 8'h00 || hdr_q.lc > `CIPV_LC_MAX
               || hdr_q.lc > {1'b0, reclen_q}) begin
            ex_sw = `CIPV_SW_BAD_LEN;
         end else if (!ac_ok) begin
            ex_sw = `CIPV_SW_NO_AC;
         end else begin
            ex_add = 1'b1;
            ex_sw = `CIPV_SW_OK;
         end
      end else if (hdr_q.ins == `CIPV_INS_VFY) begin
         if (hdr_q.p1 != 8'h00 || hdr_q.p2[6:5] != 2'h0 || hdr_q.p2[4:0] == 5'h00) begin
            ex_sw = `CIPV_SW_BAD_P;
         end else if (hdr_q.le_present) begin
            ex_sw = `CIPV_SW_BAD_LEN;
         end else if (!rs[1]) begin
            ex_sw = `CIPV_SW_NO_REF;
         end else if (hdr_q.lc == 8'h00) begin
            // Counter is zero when blocked, giving 63C0
            ex_sw = retry_sw(retry_q[ps]);
         end else if (hdr_q.lc != `CIPV_PIN_LEN) begin
            ex_sw = `CIPV_SW_BAD_LEN;
         end else if (blocked_q[ps]) begin
            ex_sw = `CIPV_SW_BLOCKED;
         end else if (pin_dis_q[ps]) begin
            ex_sw = `CIPV_SW_DISABLED;
         end else if (pin_in == pin_ref_q[ps]) begin
            ex_ok = 1'b1;
            ex_sw = `CIPV_SW_OK;
         end else begin
            ex_bad = 1'b1;
            ex_sw = retry_sw(retry_q[ps] - 2'h1);
         end
      end
   end
   // Events fire only in the evaluation cycle
   always_comb begin
      pin_ok_p = 2'h0;
      pin_bad_p = 2'h0;
      if (st_q == S_EXEC) begin
         pin_ok_p[ps] = ex_ok;
         pin_bad_p[ps] = ex_bad;
      end
   end
   // Software unblock, one-cycle pulse per PIN
   assign unblk_p = (wr_hit && reg_req.addr == `CIPV_R_PINCTL) ? reg_req.wdata[3:2] : 2'h0;
   // **********
   // Sequencer
   // **********
   assign cmd_ready = (st_q == S_IDLE);
   assign din_ready = (st_q == S_RX);
   // Header, receive, add, send, status
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         hdr_q <= '0;
         cnt_q <= 8'h00;
         idx_q <= 7'h00;
         carry_q <= 1'b0;
         sw_q <= `CIPV_SW_OK;
         cur_q <= 2'h0;
      end else begin
         case (st_q)
            S_IDLE: begin
               if (cmd_valid) begin
                  hdr_q <= cmd;
                  cnt_q <= 8'h00;
                  st_q <= (cmd.lc == 8'h00) ? S_EXEC : S_RX;
               end
            end
            S_RX: begin
               // Take Lc bytes, keeping the first 128
               if (din_valid) begin
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q == hdr_q.lc - 8'h01) st_q <= S_EXEC;
               end
            end
            S_EXEC: begin
               sw_q <= ex_sw;
               idx_q <= reclen_q - 7'h01;
               carry_q <= 1'b0;
               cnt_q <= 8'h00;
               st_q <= ex_add ? S_ADD : S_DONE;
            end
            S_ADD: begin
               // One byte per cycle, last byte first
               carry_q <= add_sum[8];
               if (idx_q == 7'h00) begin
                  if (add_sum[8]) begin
                     sw_q <= `CIPV_SW_MAX;
                     st_q <= S_DONE;
                  end else begin
                     st_q <= S_TX;
                  end
               end else begin
                  idx_q <= idx_q - 7'h01;
               end
            end
            S_TX: begin
               // Record first, then the added value
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == {1'b0, reclen_q} + hdr_q.lc - 8'h01) begin
                  cur_q <= old_slot;
                  st_q <= S_DONE;
               end
            end
            S_DONE: st_q <= S_IDLE;
            default: st_q <= S_IDLE;
         endcase
      end
   end
   // Adder, one record byte per cycle
   always_comb begin
      add_off = reclen_q - hdr_q.lc[6:0];
      add_byte = (idx_q >= add_off) ? din_buf[idx_q - add_off] : 8'h00;
      add_sum = {1'b0, rec_mem[cur_q][idx_q]} + {1'b0, add_byte} + {8'h00, carry_q};
   end
   // Byte buffers; the sum is staged so overflow leaves records intact
   always_ff @(posedge clk) begin
      if (st_q == S_RX && din_valid && !cnt_q[7]) begin
         din_buf[cnt_q[6:0]] <= din_byte;
      end
      if (st_q == S_ADD) begin
         sum_buf[idx_q] <= add_sum[7:0];
      end
   end
   // Records: commit during send, else software access
   always_ff @(posedge clk) begin
      if (st_q == S_TX && cnt_q < {1'b0, reclen_q}) begin
         rec_mem[old_slot][cnt_q[6:0]] <= sum_buf[cnt_q[6:0]];
      end else if (wr_hit && reg_req.addr == `CIPV_R_RECDATA) begin
         rec_mem[racc_slot_q][racc_byte_q] <= reg_req.wdata[7:0];
      end
   end
   // Response bytes, registered
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dout_valid_q <= 1'b0;
         dout_byte_q <= 8'h00;
      end else begin
         dout_valid_q <= (st_q == S_TX);
         if (st_q == S_TX) begin
            if (cnt_q < {1'b0, reclen_q}) begin
               dout_byte_q <= sum_buf[cnt_q[6:0]];
            end else begin
               dout_byte_q <= din_buf[7'(cnt_q - {1'b0, reclen_q})];
            end
         end
      end
   end
   assign dout_valid = dout_valid_q;
   assign dout_byte = dout_byte_q;
   assign resp_valid = (st_q == S_DONE);
   assign resp_sw = sw_q;
   // **********
   // PIN state, one copy per PIN
   // **********
   for (genvar i = 0; i < 2; i++) begin : g_pin
      // Counter survives sessions; reset, a software unblock or a correct PIN reloads it
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            retry_q[i] <= `CIPV_RETRY_INIT;
            blocked_q[i] <= 1'b0;
         end else if (unblk_p[i]) begin
            retry_q[i] <= `CIPV_RETRY_INIT;
            blocked_q[i] <= 1'b0;
         end else if (pin_ok_p[i]) begin
            retry_q[i] <= `CIPV_RETRY_INIT;
         end else if (pin_bad_p[i]) begin
            retry_q[i] <= retry_q[i] - 2'h1;
            if (retry_q[i] == 2'h1) blocked_q[i] <= 1'b1;
         end
      end
      // One flag for all channels; a new session drops it
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            verified_q[i] <= 1'b0;
         end else if (pin_ok_p[i]) begin
            verified_q[i] <= 1'b1;
         end else if (pin_bad_p[i] || session_start) begin
            verified_q[i] <= 1'b0;
         end
      end
   end
   // **********
   // Register file and interrupts
   // **********
   // Configuration written by software
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ac_tag_q <= 8'h00;
         ac_ins_q <= 8'h00;
         ac_cond_q <= 2'h0;
         sfi_q <= 5'h00;
         pin_dis_q <= 2'h0;
         reclen_q <= `CIPV_RECLEN_RST;
         racc_byte_q <= 7'h00;
         racc_slot_q <= 2'h0;
         pin_ref_q <= '{default: 64'h0};
         irq_mask_q <= 4'h0;
      end else if (wr_hit) begin
         case (reg_req.addr)
            `CIPV_R_ACRULE: begin
               ac_tag_q <= reg_req.wdata[7:0];
               ac_ins_q <= reg_req.wdata[15:8];
               ac_cond_q <= reg_req.wdata[17:16];
               sfi_q <= reg_req.wdata[22:18];
            end
            `CIPV_R_PINCTL: pin_dis_q <= reg_req.wdata[1:0];
            // Zero length is refused
            `CIPV_R_RECLEN: begin
               if (reg_req.wdata[6:0] != 7'h00) reclen_q <= reg_req.wdata[6:0];
            end
            `CIPV_R_RECACC: begin
               racc_byte_q <= reg_req.wdata[6:0];
               racc_slot_q <= reg_req.wdata[9:8];
            end
            `CIPV_R_PIN0_LO: pin_ref_q[0][31:0] <= reg_req.wdata;
            `CIPV_R_PIN0_HI: pin_ref_q[0][63:32] <= reg_req.wdata;
            `CIPV_R_PIN1_LO: pin_ref_q[1][31:0] <= reg_req.wdata;
            `CIPV_R_PIN1_HI: pin_ref_q[1][63:32] <= reg_req.wdata;
            `CIPV_R_IRQ_MASK: irq_mask_q <= reg_req.wdata[3:0];
            default: ;
         endcase
      end
   end
   // Read port; PIN references read as zero so secrets never leave
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            `CIPV_R_ACRULE: rdata_q <= {9'h0, sfi_q, ac_cond_q, ac_ins_q, ac_tag_q};
            `CIPV_R_PINCTL: rdata_q <= {30'h0, pin_dis_q};
            `CIPV_R_PINSTAT: rdata_q <= {22'h0, cur_q, verified_q,
               blocked_q, retry_q[1], retry_q[0]};
            `CIPV_R_RECLEN: rdata_q <= {25'h0, reclen_q};
            `CIPV_R_RECACC: rdata_q <= {22'h0, racc_slot_q, 1'b0, racc_byte_q};
            `CIPV_R_RECDATA: rdata_q <= {24'h0, rec_mem[racc_slot_q][racc_byte_q]};
            `CIPV_R_IRQ_STAT: rdata_q <= {28'h0, irq_stat_q};
            `CIPV_R_IRQ_MASK: rdata_q <= {28'h0, irq_mask_q};
            default: rdata_q <= 32'h0;
         endcase
      end else begin
         rdata_q <= 32'h0;
      end
   end
   assign reg_rdata = rdata_q;
   // Interrupt events
   always_comb begin
      irq_ev = 4'h0;
      irq_ev[`CIPV_IRQ_DONE] = (st_q == S_DONE);
      irq_ev[`CIPV_IRQ_BLOCK] = (pin_bad_p[ps] && retry_q[ps] == 2'h1);
      irq_ev[`CIPV_IRQ_INC] = (st_q == S_TX && sw_q == `CIPV_SW_OK
         && cnt_q == {1'b0, reclen_q} + hdr_q.lc - 8'h01);
      irq_ev[`CIPV_IRQ_BADPIN] = |pin_bad_p;
   end
   // Sticky status; a new event beats a write-one clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_stat_q <= 4'h0;
      end else if (wr_hit && reg_req.addr == `CIPV_R_IRQ_STAT) begin
         irq_stat_q <= (irq_stat_q & ~reg_req.wdata[3:0]) | irq_ev;
      end else begin
         irq_stat_q <= irq_stat_q | irq_ev;
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);
endmodule : cipv_core

/* File: verif/cipv_core_assertions.sv */
// Port checker for the card command engine
`timescale 1ns/1ps
module cipv_core_assertions import cipv_pkg::*; (
   input logic clk,
   input logic rst_n,
   input logic cmd_valid,
   input cipv_cmd_t cmd,
   input logic cmd_ready,
   input logic din_valid,
   input logic din_ready,
   input logic dout_valid,
   input logic resp_valid,
   input logic [15:0] resp_sw,
   input cipv_reg_req_t reg_req
);
   logic [7:0] ins_q, p1_q, p2_q, lc_q, cnt_q, nb_q; // Header copy, byte counts
   logic le_q;
   logic [6:0] len_q; // Record length mirror
   logic take, last, vok;
   assign take = cmd_valid && cmd_ready;
   assign last = din_valid && din_ready && nb_q + 8'h01 == lc_q;
   // Well formed verify on a known reference
   assign vok = ins_q == 8'h20 && p1_q == 8'h00 && !le_q && p2_q[6:0] == 7'h01;
   // Header of the running command
   always_ff @(posedge clk) begin
      if (take) begin
         {ins_q, p1_q, p2_q, lc_q, le_q} <= {cmd.ins, cmd.p1, cmd.p2, cmd.lc, cmd.le_present};
      end
   end
   // Counts restart per command
   always_ff @(posedge clk) begin
      if (!rst_n || take) begin
         cnt_q <= 8'h00;
         nb_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + {7'h00, dout_valid};
         nb_q <= nb_q + {7'h00, din_valid && din_ready};
      end
   end
   // Zero writes leave the length alone
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         len_q <= 7'h08;
      end else if (reg_req.wr && reg_req.addr == 8'h0c && reg_req.wdata[6:0] != 7'h00) begin
         len_q <= reg_req.wdata[6:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_retry_max: assert property (
      resp_valid && resp_sw[15:4] == 12'h63c |-> resp_sw[3:0] <= 4'h3)
      else $error("retry count above three");
   a_fail_silent: assert property (
      resp_valid && resp_sw != 16'h9000 |-> cnt_q == 8'h00 && !dout_valid)
      else $error("data sent on refused command");
   a_resp_length: assert property (
      resp_valid && ins_q == 8'h32 && resp_sw == 16'h9000
      |-> cnt_q + {7'h00, dout_valid} == {1'b0, len_q} + lc_q)
      else $error("increase answer length wrong");
   a_pin_length: assert property (
      resp_valid && vok && lc_q != 8'h00 && lc_q != 8'h08 |-> resp_sw == 16'h6700)
      else $error("bad pin length accepted");
   a_query_retry: assert property (
      resp_valid && vok && lc_q == 8'h00 |-> resp_sw[15:4] == 12'h63c)
      else $error("query not answered with retries");
   a_inc_qual: assert property (
      resp_valid && ins_q == 8'h32 && p2_q != 8'h00 |-> resp_sw == 16'h6b00)
      else $error("increase qualifier not refused");
   a_inc_len: assert property (
      resp_valid && ins_q == 8'h32 && p1_q == 8'h00 && p2_q == 8'h00
      && (lc_q == 8'h00 || lc_q[7]) |-> resp_sw == 16'h6700)
      else $error("increase length not refused");
   a_vfy_qual: assert property (
      resp_valid && ins_q == 8'h20 && p2_q[6:5] != 2'b00 |-> resp_sw == 16'h6b00)
      else $error("verify qualifier not refused");
   a_verify_time: assert property (
      last && ins_q == 8'h20 |-> ##1 !resp_valid ##1 resp_valid)
      else $error("verify answer late");
   a_query_time: assert property (
      take && cmd.lc == 8'h00 |-> ##1 !resp_valid ##1 resp_valid)
      else $error("empty command answer late");
   c_blocked: cover property (resp_valid && resp_sw == 16'h63c0);
   c_overflow: cover property (resp_valid && resp_sw == 16'h9850);
   c_inc_ok: cover property (resp_valid && ins_q == 8'h32 && resp_sw == 16'h9000);
endmodule : cipv_core_assertions
bind cipv_core cipv_core_assertions u_chk (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
   .cmd(cmd), .cmd_ready(cmd_ready), .din_valid(din_valid), .din_ready(din_ready),
   .dout_valid(dout_valid), .resp_valid(resp_valid), .resp_sw(resp_sw), .reg_req(reg_req));

/* File: verif/cipv_term_model.sv */
// Terminal model: sends headers and data, gathers the answer
`timescale 1ns/1ps
module cipv_term_model import cipv_pkg::*; (
   input logic clk,
   output cipv_cmd_t cmd,
   output logic cmd_valid,
   input logic cmd_ready,
   output logic din_valid,
   output logic [7:0] din_byte,
   input logic din_ready,
   input logic dout_valid,
   input logic [7:0] dout_byte,
   input logic resp_valid,
   input logic [15:0] resp_sw
);
   logic [7:0] rx[$]; // Answer bytes
   logic [15:0] sw = 16'h0000; // Answer status
   logic hung = 1'b0; // Card never answered
   logic busy = 1'b0;
   initial begin
      cmd = '0;
      cmd_valid = 1'b0;
      din_valid = 1'b0;
      din_byte = 8'h00;
   end
   // Sample at the falling edge, once settled
   always @(negedge clk) begin
      if (busy && dout_valid) rx.push_back(dout_byte);
      if (busy && resp_valid) begin
         sw = resp_sw;
         busy = 1'b0;
      end
   end
   // Hold the offer until ready is seen
   task automatic hold(input bit hdr);
      logic ok;
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(negedge clk);
         ok = hdr ? cmd_ready : din_ready;
         @(posedge clk);
      end
      if (!ok) hung = 1'b1;
   endtask : hold
   // One command; gap idles mimic a slow terminal
   task automatic xfer(input logic [7:0] ins, p1, p2, lc, input logic [127:0] d, input int gap);
      rx.delete();
      sw = 16'hxxxx;
      busy = 1'b1;
      cmd <= '{8'h00, ins, p1, p2, lc, 1'b0};
      cmd_valid <= 1'b1;
      hold(1'b1);
      cmd_valid <= 1'b0;
      cmd <= ~cmd;
      // Exactly lc bytes; a released line shows the inverse
      for (int i = 0; i < lc; i++) begin
         if (gap > 0) begin
            din_valid <= 1'b0;
            din_byte <= ~din_byte;
            repeat (gap) @(posedge clk);
         end
         din_byte <= d[127-8*i -: 8];
         din_valid <= 1'b1;
         hold(1'b0);
      end
      din_valid <= 1'b0;
      din_byte <= ~din_byte;
      for (int n = 0; n < 2000 && busy; n++) @(posedge clk);
      if (busy) hung = 1'b1;
   endtask : xfer
endmodule : cipv_term_model

/* File: verif/testbench.sv */
// Self-checking bench of the card command engine
`timescale 1ns/1ps
`include "cipv_map.svh"
module testbench import cipv_pkg::*;;
   logic clk, rst_n, session_start, cmd_valid, cmd_ready, din_valid, din_ready;
   logic dout_valid, resp_valid, irq;
   logic [7:0] din_byte, dout_byte;
   logic [15:0] resp_sw;
   logic [31:0] reg_rdata, rv;
   cipv_cmd_t cmd;
   cipv_reg_req_t reg_req;
   localparam logic [63:0] PIN_A = 64'h3132333435363738; // Slot 0 reference
   localparam logic [63:0] PIN_B = 64'h5a1b2c3d4e5f6071; // Slot 1 reference
   int num_errors = 0;
   int tests_run = 0;
   int gap = 0; // Slow terminal when nonzero
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   cipv_core u_cipv_core (.clk(clk), .rst_n(rst_n), .session_start(session_start),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .din_valid(din_valid),
      .din_byte(din_byte), .din_ready(din_ready), .dout_valid(dout_valid),
      .dout_byte(dout_byte), .resp_valid(resp_valid), .resp_sw(resp_sw),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));
   cipv_term_model u_term (.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .din_valid(din_valid), .din_byte(din_byte),
      .din_ready(din_ready), .dout_valid(dout_valid), .dout_byte(dout_byte),
      .resp_valid(resp_valid), .resp_sw(resp_sw));
   // **********
   // Shared tasks
   // **********
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   // Idle cycle after each access
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      reg_req <= '0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk);
      reg_req <= '0;
      @(negedge clk);
      d = reg_rdata;
      @(posedge clk);
   endtask : rd
   task automatic irq_is(input logic e);
      @(negedge clk);
      chk("irq", {31'h0, e}, {31'h0, irq});
      @(posedge clk);
   endtask : irq_is
   task automatic session();
      session_start <= 1'b1;
      @(posedge clk);
      session_start <= 1'b0;
   endtask : session
   task automatic run(input logic [7:0] ins, p1, p2, lc, input logic [127:0] d,
                      input logic [15:0] e);
      u_term.xfer(ins, p1, p2, lc, d, gap);
      if (u_term.hung) begin
         num_errors++;
         test_done();
      end
      chk("status", {16'h0, e}, {16'h0, u_term.sw});
   endtask : run
   task automatic vfy(input logic [7:0] p2, lc, input logic [63:0] pin, input logic [15:0] e);
      run(8'h20, 8'h00, p2, lc, {pin, 64'h0}, e);
   endtask : vfy
   task automatic inc1(input logic [15:0] e);
      run(8'h32, 8'h00, 8'h00, 8'h01, {8'h01, 120'h0}, e);
   endtask : inc1
   task automatic bytes(input logic [7:0] e[$]);
      chk("resp count", 32'(e.size()), 32'(u_term.rx.size()));
      for (int i = 0; i < e.size() && i < u_term.rx.size(); i++) begin
         chk("resp byte", {24'h0, e[i]}, {24'h0, u_term.rx[i]});
      end
   endtask : bytes
   // **********
   // Scenarios
   // **********
   task automatic t_regs();
      rd(`CIPV_R_PINSTAT, rv);
      chk("pinstat", 32'hf, rv);
      rd(8'h30, rv);
      chk("unmapped", 32'h0, rv);
      wr(`CIPV_R_PIN0_LO, PIN_A[31:0]);
      wr(`CIPV_R_PIN0_HI, PIN_A[63:32]);
      wr(`CIPV_R_PIN1_LO, PIN_B[31:0]);
      wr(`CIPV_R_PIN1_HI, PIN_B[63:32]);
      $display("test regs done");
   endtask : t_regs
   task automatic t_retry();
      vfy(8'h01, 8'h08, PIN_B, 16'h63c2);
      session();
      vfy(8'h01, 8'h08, PIN_B, 16'h63c1);
      vfy(8'h01, 8'h08, PIN_B, 16'h63c0);
      irq_is(1'b0);
      wr(`CIPV_R_IRQ_MASK, 32'h2);
      irq_is(1'b1);
      vfy(8'h01, 8'h08, PIN_A, 16'h6983);
      vfy(8'h01, 8'h00, 64'h0, 16'h63c0);
      rd(`CIPV_R_PINSTAT, rv);
      chk("pinstat", 32'h1c, rv);
      wr(`CIPV_R_IRQ_STAT, 32'hf);
      irq_is(1'b0);
      $display("test retry done");
   endtask : t_retry
   task automatic t_pin1();
      gap = 2;
      vfy(8'h81, 8'h00, 64'h0, 16'h63c3);
      vfy(8'h81, 8'h04, PIN_A, 16'h6700);
      vfy(8'h81, 8'h00, 64'h0, 16'h63c3);
      vfy(8'h81, 8'h08, PIN_A, 16'h63c2);
      vfy(8'h81, 8'h08, PIN_B, 16'h9000);
      vfy(8'h81, 8'h00, 64'h0, 16'h63c3);
      vfy(8'h41, 8'h00, 64'h0, 16'h6b00);
      gap = 0;
      rd(`CIPV_R_PINSTAT, rv);
      chk("verified", 32'h2, {30'h0, rv[7:6]});
      $display("test pin1 done");
   endtask : t_pin1
   task automatic t_inc();
      logic [39:0] tb[4] = '{40'h8600016a82, 40'h0001016b00, 40'h4000016b00, 40'h0000006700};
      wr(`CIPV_R_ACRULE, 32'h00143284);
      wr(`CIPV_R_RECLEN, 32'h2);
      wr(`CIPV_R_RECACC, 32'h1);
      wr(`CIPV_R_RECDATA, 32'h10);
      wr(`CIPV_R_RECACC, 32'h0);
      wr(`CIPV_R_RECDATA, 32'h0);
      run(8'h32, 8'h00, 8'h00, 8'h01, {8'h05, 120'h0}, 16'h9000);
      bytes('{8'h00, 8'h15, 8'h05});
      rd(`CIPV_R_PINSTAT, rv);
      chk("record 1 slot", 32'h1, {30'h0, rv[9:8]});
      run(8'h32, 8'h85, 8'h00, 8'h02, {16'h0101, 112'h0}, 16'h9000);
      bytes('{8'h01, 8'h16, 8'h01, 8'h01});
      wr(`CIPV_R_RECACC, 32'h200);
      wr(`CIPV_R_RECDATA, 32'hff);
      wr(`CIPV_R_RECACC, 32'h201);
      wr(`CIPV_R_RECDATA, 32'hfe);
      inc1(16'h9000);
      bytes('{8'hff, 8'hff, 8'h01});
      inc1(16'h9850);
      chk("resp count", 32'h0, 32'(u_term.rx.size()));
      for (int i = 0; i < 4; i++) begin
         run(8'h32, tb[i][39:32], tb[i][31:24], tb[i][23:16], 128'h0, tb[i][15:0]);
      end
      wr(`CIPV_R_ACRULE, 32'h00173284);
      inc1(16'h6982);
      wr(`CIPV_R_ACRULE, 32'h00142084);
      inc1(16'h6982);
      wr(`CIPV_R_ACRULE, 32'h00163284);
      inc1(16'h9850);
      session();
      inc1(16'h6982);
      wr(`CIPV_R_PINCTL, 32'h2);
      inc1(16'h9850);
      vfy(8'h81, 8'h08, PIN_B, 16'h6984);
      $display("test increase done");
   endtask : t_inc
   initial begin
      rst_n = 1'b0;
      session_start = 1'b0;
      reg_req = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_retry();
      t_pin1();
      t_inc();
      test_done();
   end
endmodule : testbench
